/* verilog/rca_pkg.sv */
// Constants, register map and shared helper functions of the RTC control block
package rca_pkg;
	// Timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned TICK_HZ = 256;
	localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
	localparam int unsigned ADJ_READ_WAIT_NS = 91600;
	localparam int unsigned ADJ_READ_WAIT_CYC =
		(ADJ_READ_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned DIVRST_READ_WAIT_NS = 107000;
	localparam int unsigned DIVRST_READ_WAIT_CYC =
		(DIVRST_READ_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// Register map, byte addresses
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_SUBSEC = 6'h00;
	localparam logic [5:0] OFS_CNT_BASE = 6'h04;
	localparam logic [5:0] OFS_CNT_LAST = 6'h1c;
	localparam logic [5:0] OFS_ALM_BASE = 6'h20;
	localparam logic [5:0] OFS_ALM_LAST = 6'h34;
	localparam logic [5:0] OFS_CTRL1 = 6'h38;
	localparam logic [5:0] OFS_CTRL2 = 6'h3c;

	localparam int NUM_ALM = 6;
	localparam logic [2:0] F_SEC = 3'h0;
	localparam logic [2:0] F_MIN = 3'h1;
	localparam logic [2:0] F_HOUR = 3'h2;
	localparam logic [2:0] F_WDAY = 3'h3;
	localparam logic [2:0] F_DATE = 3'h4;
	localparam logic [2:0] F_MON = 3'h5;
	localparam logic [2:0] F_YEAR = 3'h6;

	// Control field positions
	localparam int C1_CF = 7;
	localparam int C1_CIE = 4;
	localparam int C1_AIE = 3;
	localparam int C1_AF = 0;
	localparam int C2_PEF = 7;
	localparam int C2_PES_LSB = 4;
	localparam int C2_OSC = 3;
	localparam int C2_ADJ = 2;
	localparam int C2_DIVRST = 1;
	localparam int C2_START = 0;
	localparam int ALM_ARM_BIT = 7;

	// Values after reset
	localparam logic [2:0] PES_RST = 3'h0;
	localparam logic OSC_EN_RST = 1'b1;
	localparam logic START_RST = 1'b1;
	localparam logic [7:0] SEC_RST = 8'h00;
	localparam logic [7:0] DATE_RST = 8'h01;
	localparam logic [7:0] MON_RST = 8'h01;

	// Calendar limits
	localparam logic [7:0] SEC_LAST = 8'h59;
	localparam logic [7:0] MIN_LAST = 8'h59;
	localparam logic [7:0] HOUR_LAST = 8'h23;
	localparam logic [7:0] WDAY_LAST = 8'h06;
	localparam logic [7:0] MON_LAST = 8'h12;
	localparam logic [7:0] YEAR_LAST = 8'h99;
	localparam logic [7:0] DAY_FIRST = 8'h01;
	localparam logic [7:0] ROUND_UP_SEC = 8'h30;

	function automatic logic [7:0] field_mask(input logic [2:0] idx);
		logic [7:0] m;
		m = 8'hff;
		if (idx == F_SEC || idx == F_MIN) begin
			m = 8'h7f;
		end else if (idx == F_HOUR || idx == F_DATE) begin
			m = 8'h3f;
		end else if (idx == F_WDAY) begin
			m = 8'h07;
		end else if (idx == F_MON) begin
			m = 8'h1f;
		end
		return m;
	endfunction : field_mask

	function automatic logic [7:0] bcd_step(input logic [7:0] v);
		if (v[3:0] >= 4'h9) begin
			return {v[7:4] + 4'h1, 4'h0};
		end
		return {v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_step

	function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
			(yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
		if (mon == 8'h02) begin
			return leap ? 8'h29 : 8'h28;
		end
		if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
			return 8'h30;
		end
		return 8'h31;
	endfunction : days_in

	// True on the 1/256 s tick that closes the selected interval
	function automatic logic period_hit(input logic [2:0] pes, input logic [8:0] sub);
		logic h;
		h = 1'b0;
		if (pes == 3'h1) begin
			h = 1'b1;
		end else if (pes == 3'h2) begin
			h = &sub[1:0];
		end else if (pes == 3'h3) begin
			h = &sub[3:0];
		end else if (pes == 3'h4) begin
			h = &sub[5:0];
		end else if (pes == 3'h5) begin
			h = &sub[6:0];
		end else if (pes == 3'h6) begin
			h = &sub[7:0];
		end else if (pes == 3'h7) begin
			h = &sub[8:0];
		end
		return h;
	endfunction : period_hit
endpackage : rca_pkg

/* verilog/rca_core_if.sv */
// Signals shared between the control block, its prescaler and its calendar
interface rca_core_if;
	logic osc_en;
	logic div_reset;
	logic tick;
	logic c64_up;
	logic sec_wrap;
	logic [8:0] sub_cnt;
	logic count_en;
	logic round;
	logic wr_en;
	logic [2:0] wr_sel;
	logic [7:0] wr_data;
	logic [7:0] sec;
	logic [7:0] min;
	logic [7:0] hour;
	logic [7:0] wday;
	logic [7:0] date;
	logic [7:0] mon;
	logic [7:0] year;

	modport presc (input osc_en, div_reset, output tick, c64_up, sec_wrap, sub_cnt);
	modport cal (input sec_wrap, count_en, round, wr_en, wr_sel, wr_data,
		output sec, min, hour, wday, date, mon, year);
	modport ctrl (output osc_en, div_reset, count_en, round, wr_en, wr_sel, wr_data,
		input tick, c64_up, sec_wrap, sub_cnt, sec, min, hour, wday, date, mon, year);
endinterface : rca_core_if

/* verilog/rca_prescaler.sv */
// Prescaler and sub-second counter, stepping at 1/256 s
module rca_prescaler #(
	parameter int unsigned TICK_CYCLES = rca_pkg::TICK_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	rca_core_if.presc core
);
	localparam int CW = $clog2(TICK_CYCLES);

	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("TICK_CYCLES must be at least 2");
	end

	logic [CW-1:0] div_reg, div_next;
	logic [8:0] sub_reg, sub_next;
	logic tick;

	always_comb begin
		div_next = div_reg;
		sub_next = sub_reg;
		tick = 1'b0;
		if (core.div_reset) begin
			div_next = '0;
			sub_next = 9'h000;
		end else if (core.osc_en) begin
			if (div_reg == CW'(TICK_CYCLES - 1)) begin
				div_next = '0;
				tick = 1'b1;
				sub_next = sub_reg + 9'h001;
			end else begin
				div_next = div_reg + CW'(1);
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			div_reg <= '0;
			sub_reg <= 9'h000;
		end else if (i_ce) begin
			div_reg <= div_next;
			sub_reg <= sub_next;
		end
	end

	// Bits 7:2 form the 64 Hz count; bit 8 splits the 2 s period
	assign core.tick = tick;
	assign core.c64_up = tick & (&sub_reg[1:0]);
	assign core.sec_wrap = tick & (&sub_reg[7:0]);
	assign core.sub_cnt = sub_reg;
endmodule : rca_prescaler

/* verilog/rca_calendar.sv */
// BCD time and calendar counters with rounding and software load
module rca_calendar (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	rca_core_if.cal core
);
	logic [7:0] sec_reg, sec_next, min_reg, min_next, hour_reg, hour_next;
	logic [7:0] wday_reg, wday_next, date_reg, date_next, mon_reg, mon_next;
	logic [7:0] year_reg, year_next;
	logic c_min, c_hr, c_day, c_mon, c_yr;

	always_comb begin
		sec_next = sec_reg;
		min_next = min_reg;
		hour_next = hour_reg;
		wday_next = wday_reg;
		date_next = date_reg;
		mon_next = mon_reg;
		year_next = year_reg;
		c_min = 1'b0;
		c_hr = 1'b0;
		c_day = 1'b0;
		c_mon = 1'b0;
		c_yr = 1'b0;
		// Rounding wins over a tick in the same cycle; it restarts the divider anyway
		if (core.round) begin
			sec_next = 8'h00;
			c_min = (sec_reg >= rca_pkg::ROUND_UP_SEC);
		end else if (core.count_en && core.sec_wrap) begin
			if (sec_reg == rca_pkg::SEC_LAST) begin
				sec_next = 8'h00;
				c_min = 1'b1;
			end else begin
				sec_next = rca_pkg::bcd_step(sec_reg);
			end
		end
		if (c_min) begin
			if (min_reg == rca_pkg::MIN_LAST) begin
				min_next = 8'h00;
				c_hr = 1'b1;
			end else begin
				min_next = rca_pkg::bcd_step(min_reg);
			end
		end
		if (c_hr) begin
			if (hour_reg == rca_pkg::HOUR_LAST) begin
				hour_next = 8'h00;
				c_day = 1'b1;
			end else begin
				hour_next = rca_pkg::bcd_step(hour_reg);
			end
		end
		if (c_day) begin
			wday_next = (wday_reg == rca_pkg::WDAY_LAST) ? 8'h00 : wday_reg + 8'h01;
			if (date_reg == rca_pkg::days_in(mon_reg, year_reg)) begin
				date_next = rca_pkg::DAY_FIRST;
				c_mon = 1'b1;
			end else begin
				date_next = rca_pkg::bcd_step(date_reg);
			end
		end
		if (c_mon) begin
			if (mon_reg == rca_pkg::MON_LAST) begin
				mon_next = rca_pkg::DAY_FIRST;
				c_yr = 1'b1;
			end else begin
				mon_next = rca_pkg::bcd_step(mon_reg);
			end
		end
		if (c_yr) begin
			year_next = (year_reg == rca_pkg::YEAR_LAST) ? 8'h00 : rca_pkg::bcd_step(year_reg);
		end
		if (core.wr_en) begin
			if (core.wr_sel == rca_pkg::F_SEC) begin
				sec_next = core.wr_data & rca_pkg::field_mask(rca_pkg::F_SEC);
			end else if (core.wr_sel == rca_pkg::F_MIN) begin
				min_next = core.wr_data & rca_pkg::field_mask(rca_pkg::F_MIN);
			end else if (core.wr_sel == rca_pkg::F_HOUR) begin
				hour_next = core.wr_data & rca_pkg::field_mask(rca_pkg::F_HOUR);
			end else if (core.wr_sel == rca_pkg::F_WDAY) begin
				wday_next = core.wr_data & rca_pkg::field_mask(rca_pkg::F_WDAY);
			end else if (core.wr_sel == rca_pkg::F_DATE) begin
				date_next = core.wr_data & rca_pkg::field_mask(rca_pkg::F_DATE);
			end else if (core.wr_sel == rca_pkg::F_MON) begin
				mon_next = core.wr_data & rca_pkg::field_mask(rca_pkg::F_MON);
			end else if (core.wr_sel == rca_pkg::F_YEAR) begin
				year_next = core.wr_data;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			sec_reg <= rca_pkg::SEC_RST;
			min_reg <= rca_pkg::SEC_RST;
			hour_reg <= rca_pkg::SEC_RST;
			wday_reg <= rca_pkg::SEC_RST;
			date_reg <= rca_pkg::DATE_RST;
			mon_reg <= rca_pkg::MON_RST;
			year_reg <= rca_pkg::SEC_RST;
		end else if (i_ce) begin
			sec_reg <= sec_next;
			min_reg <= min_next;
			hour_reg <= hour_next;
			wday_reg <= wday_next;
			date_reg <= date_next;
			mon_reg <= mon_next;
			year_reg <= year_next;
		end
	end

	assign core.sec = sec_reg;
	assign core.min = min_reg;
	assign core.hour = hour_reg;
	assign core.wday = wday_reg;
	assign core.date = date_reg;
	assign core.mon = mon_reg;
	assign core.year = year_reg;
endmodule : rca_calendar

/* verilog/rca_top.sv */
// RTC control: Avalon-MM registers, alarm, carry and periodic flags
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
module rca_top #(
	parameter int unsigned TICK_CYCLES = rca_pkg::TICK_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_alarm_irq,
	output logic o_carry_irq,
	output logic o_periodic_irq
);
	rca_core_if core ();

	rca_prescaler #(.TICK_CYCLES(TICK_CYCLES)) u_presc (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.core(core.presc)
	);

	rca_calendar u_cal (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.core(core.cal)
	);

	// Bus handshake: data is prepared on the first edge, taken on the second
	logic ack_reg, ack_next;
	logic [7:0] rdata_reg, rdata_next;
	logic wr_take;
	logic [7:0] wdata;
	logic [7:0] rd_val;
	logic [2:0] cnt_idx, alm_idx;
	logic is_cnt, is_alm;

	// Control state
	logic cf_reg, cf_next, cie_reg, cie_next, aie_reg, aie_next, af_reg, af_next;
	logic pef_reg, pef_next, osc_reg, osc_next, start_reg, start_next;
	logic [2:0] pes_reg, pes_next;
	logic [7:0] alm_reg [rca_pkg::NUM_ALM];
	logic [7:0] alm_next [rca_pkg::NUM_ALM];
	logic match_prev_reg, match_next;
	logic match, any_armed, match_rise;
	logic [7:0] cal_val [rca_pkg::NUM_ALM];
	logic wr_c1, wr_c2, period_evt;

	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~(ack_reg & i_ce);
	assign wr_take = i_avs_write & ack_reg & i_ce & i_avs_byteenable[0];
	assign wdata = i_avs_writedata[7:0];
	assign cnt_idx = 3'((i_avs_address - rca_pkg::OFS_CNT_BASE) >> 2);
	assign alm_idx = 3'((i_avs_address - rca_pkg::OFS_ALM_BASE) >> 2);
	assign is_cnt = (i_avs_address >= rca_pkg::OFS_CNT_BASE) &&
		(i_avs_address <= rca_pkg::OFS_CNT_LAST);
	assign is_alm = (i_avs_address >= rca_pkg::OFS_ALM_BASE) &&
		(i_avs_address <= rca_pkg::OFS_ALM_LAST);
	assign wr_c1 = wr_take && (i_avs_address == rca_pkg::OFS_CTRL1);
	assign wr_c2 = wr_take && (i_avs_address == rca_pkg::OFS_CTRL2);

	assign cal_val[0] = core.sec;
	assign cal_val[1] = core.min;
	assign cal_val[2] = core.hour;
	assign cal_val[3] = core.wday;
	assign cal_val[4] = core.date;
	assign cal_val[5] = core.mon;

	// Alarm compare over armed fields only
	always_comb begin
		any_armed = 1'b0;
		match = 1'b1;
		for (int i = 0; i < rca_pkg::NUM_ALM; i++) begin
			if (alm_reg[i][rca_pkg::ALM_ARM_BIT]) begin
				any_armed = 1'b1;
				if ((alm_reg[i] & rca_pkg::field_mask(3'(i))) != cal_val[i]) begin
					match = 1'b0;
				end
			end
		end
		match = match & any_armed;
	end
	// Edge only, so a flag cleared during the matching second is not set again
	assign match_rise = match & ~match_prev_reg;
	assign period_evt = core.tick && rca_pkg::period_hit(pes_reg, core.sub_cnt);

	// Calendar and timebase steering
	assign core.osc_en = osc_reg;
	assign core.count_en = start_reg;
	assign core.round = wr_c2 && wdata[rca_pkg::C2_ADJ];
	assign core.div_reset = wr_c2 &&
		(wdata[rca_pkg::C2_DIVRST] || wdata[rca_pkg::C2_ADJ]);
	assign core.wr_en = wr_take && is_cnt && !start_reg;
	assign core.wr_sel = cnt_idx;
	assign core.wr_data = wdata;

	// Read mux
	always_comb begin
		rd_val = 8'h00;
		if (i_avs_address == rca_pkg::OFS_SUBSEC) begin
			rd_val = {2'b00, core.sub_cnt[7:2]};
		end else if (is_cnt) begin
			if (cnt_idx == rca_pkg::F_SEC) begin
				rd_val = core.sec;
			end else if (cnt_idx == rca_pkg::F_MIN) begin
				rd_val = core.min;
			end else if (cnt_idx == rca_pkg::F_HOUR) begin
				rd_val = core.hour;
			end else if (cnt_idx == rca_pkg::F_WDAY) begin
				rd_val = core.wday;
			end else if (cnt_idx == rca_pkg::F_DATE) begin
				rd_val = core.date;
			end else if (cnt_idx == rca_pkg::F_MON) begin
				rd_val = core.mon;
			end else begin
				rd_val = core.year;
			end
		end else if (is_alm) begin
			rd_val = alm_reg[alm_idx];
		end else if (i_avs_address == rca_pkg::OFS_CTRL1) begin
			rd_val = {cf_reg, 2'b00, cie_reg, aie_reg, 2'b00, af_reg};
		end else if (i_avs_address == rca_pkg::OFS_CTRL2) begin
			rd_val = {pef_reg, pes_reg, osc_reg, 2'b00, start_reg};
		end
	end

	always_comb begin
		ack_next = (i_avs_read | i_avs_write) & ~ack_reg;
		rdata_next = rdata_reg;
		if (i_avs_read && !ack_reg) begin
			rdata_next = rd_val;
		end
	end

	always_comb begin
		cf_next = cf_reg;
		cie_next = cie_reg;
		aie_next = aie_reg;
		af_next = af_reg;
		pef_next = pef_reg;
		pes_next = pes_reg;
		osc_next = osc_reg;
		start_next = start_reg;
		match_next = match;
		for (int i = 0; i < rca_pkg::NUM_ALM; i++) begin
			alm_next[i] = alm_reg[i];
		end
		if (wr_take && is_alm) begin
			alm_next[alm_idx] = wdata & (rca_pkg::field_mask(alm_idx) | 8'h80);
		end
		if (wr_c1) begin
			cf_next = wdata[rca_pkg::C1_CF];
			cie_next = wdata[rca_pkg::C1_CIE];
			aie_next = wdata[rca_pkg::C1_AIE];
			af_next = af_reg & wdata[rca_pkg::C1_AF];
		end
		if (wr_c2) begin
			pef_next = wdata[rca_pkg::C2_PEF];
			pes_next = wdata[rca_pkg::C2_PES_LSB +: 3];
			osc_next = wdata[rca_pkg::C2_OSC];
			start_next = wdata[rca_pkg::C2_START];
		end
		// Hardware events win over a software clear in the same cycle
		if (core.c64_up) begin
			cf_next = 1'b1;
		end
		if (match_rise) begin
			af_next = 1'b1;
		end
		if (period_evt) begin
			pef_next = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ack_reg <= 1'b0;
			rdata_reg <= 8'h00;
			cf_reg <= 1'b0;
			cie_reg <= 1'b0;
			aie_reg <= 1'b0;
			af_reg <= 1'b0;
			pef_reg <= 1'b0;
			pes_reg <= rca_pkg::PES_RST;
			osc_reg <= rca_pkg::OSC_EN_RST;
			start_reg <= rca_pkg::START_RST;
			match_prev_reg <= 1'b0;
			for (int i = 0; i < rca_pkg::NUM_ALM; i++) begin
				alm_reg[i] <= 8'h00;
			end
		end else if (i_ce) begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			cf_reg <= cf_next;
			cie_reg <= cie_next;
			aie_reg <= aie_next;
			af_reg <= af_next;
			pef_reg <= pef_next;
			pes_reg <= pes_next;
			osc_reg <= osc_next;
			start_reg <= start_next;
			match_prev_reg <= match_next;
			for (int i = 0; i < rca_pkg::NUM_ALM; i++) begin
				alm_reg[i] <= alm_next[i];
			end
		end
	end

	assign o_avs_readdata = {24'h000000, rdata_reg};
	assign o_alarm_irq = af_reg & aie_reg;
	assign o_carry_irq = cf_reg & cie_reg;
	assign o_periodic_irq = pef_reg & (pes_reg != 3'h0);

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_adj_write;
		wr_c2 && wdata[rca_pkg::C2_ADJ];
	endsequence

	sequence s_ctrl2_read;
		i_avs_read && !ack_reg && i_ce && (i_avs_address == rca_pkg::OFS_CTRL2);
	endsequence

	chk_round_down: assert property (
		s_adj_write ##0 (core.sec <= 8'h29) |=> (core.sec == 8'h00))
		else $error("seconds not cleared by rounding");

	chk_round_carry: assert property (
		s_adj_write ##0 (core.sec >= 8'h30) |=>
			(core.sec == 8'h00) && (core.min != $past(core.min)))
		else $error("round-up did not carry into minutes");

	chk_trigger_zero: assert property (
		s_ctrl2_read ##1 !o_avs_waitrequest |-> (o_avs_readdata[2:1] == 2'b00))
		else $error("trigger bits read nonzero");

	chk_div_clear: assert property (
		wr_c2 && wdata[rca_pkg::C2_DIVRST] |=> (core.sub_cnt == 9'h000))
		else $error("divider reset left sub-second count");

	chk_halt_hold: assert property (
		i_ce && !start_reg && !core.round && !core.wr_en |=> $stable(core.sec))
		else $error("seconds moved while halted");

	chk_sub_runs: assert property (
		i_ce && !start_reg && core.tick && !core.div_reset |=>
			(core.sub_cnt != $past(core.sub_cnt)))
		else $error("sub-second count stalled while halted");

	chk_start_reset: assert property (
		wr_c2 && wdata[rca_pkg::C2_START] && wdata[rca_pkg::C2_DIVRST] |=>
			start_reg && (core.sub_cnt == 9'h000))
		else $error("joint start and divider reset not honoured");

	chk_wr_blocked: assert property (
		wr_take && is_cnt && start_reg && !core.sec_wrap && !core.round |=>
			$stable(core.sec) && $stable(core.min) && $stable(core.year))
		else $error("counter written while counting");

	chk_alarm_set: assert property (
		i_ce && match_rise |=> af_reg)
		else $error("alarm flag not set on match");

	chk_alarm_irq: assert property (
		i_ce && match_rise && aie_reg && !wr_c1 |=>
			o_alarm_irq ##1 (o_alarm_irq || $past(wr_c1)))
		else $error("alarm request missing");

	chk_periodic_set: assert property (
		i_ce && period_evt |=> pef_reg)
		else $error("periodic flag not set");

	chk_carry_set: assert property (
		i_ce && core.c64_up |=> cf_reg)
		else $error("carry flag not set");

	chk_osc_stop: assert property (
		i_ce && !osc_reg && !core.div_reset |=> $stable(core.sub_cnt))
		else $error("timebase ran with oscillator off");
endmodule : rca_top

/* verification/test_rca_top.sv */
// Self-checking bench for the RTC control block over its register bus
module test_rca_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] address = 6'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic alarm_irq;
	logic carry_irq;
	logic periodic_irq;
	logic [31:0] rd;
	logic [31:0] rd2;
	int err_count = 0;
	int n_tests = 0;

	// Short tick keeps a simulated second at 1024 clocks
	rca_top #(.TICK_CYCLES(4)) rca_top_i (
		.i_sys_clk(sys_clk),
		.i_rst_n(rst_n),
		.i_ce(1'b1),
		.i_avs_address(address),
		.i_avs_read(read),
		.i_avs_write(write),
		.i_avs_writedata(writedata),
		.i_avs_byteenable(4'h1),
		.o_avs_readdata(readdata),
		.o_avs_waitrequest(waitrequest),
		.o_alarm_irq(alarm_irq),
		.o_carry_irq(carry_irq),
		.o_periodic_irq(periodic_irq)
	);

	always #25 sys_clk = ~sys_clk;

	task automatic finish_test();
		if (err_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Waitrequest and read data are both taken at the accepting rising edge
	task automatic wait_ack();
		int i;
		for (i = 0; i < 100; i++) begin
			@(posedge sys_clk);
			if (waitrequest === 1'b0) begin
				break;
			end
		end
		if (i == 100) begin
			check(32'h1, 32'h0);
		end
		rd = readdata;
	endtask : wait_ack

	task automatic bus_write(input logic [5:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		address <= a;
		writedata <= {24'h0, d};
		write <= 1'b1;
		wait_ack();
		write <= 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [5:0] a);
		@(posedge sys_clk);
		address <= a;
		read <= 1'b1;
		wait_ack();
		read <= 1'b0;
	endtask : bus_read

	task automatic read_chk(input logic [5:0] a, input logic [7:0] e);
		bus_read(a);
		check(rd, {24'h0, e});
	endtask : read_chk

	task automatic t_reset();
		read_chk(rca_pkg::OFS_CTRL2, 8'h09);
		read_chk(rca_pkg::OFS_CTRL1, 8'h00);
		read_chk(6'h14, 8'h01);
		bus_write(rca_pkg::OFS_CTRL2, 8'h0f);
		read_chk(rca_pkg::OFS_CTRL2, 8'h09);
	endtask : t_reset

	task automatic t_halt();
		bus_write(6'h08, 8'h33);
		read_chk(6'h08, 8'h00);
		bus_write(rca_pkg::OFS_CTRL2, 8'h08);
		// Program every clock register once counting is halted
		for (int a = 4; a < 56; a += 4) begin
			bus_write(6'(a), 8'h01);
		end
		read_chk(6'h1c, 8'h01);
		bus_write(6'h04, 8'h30);
		repeat (1100) @(posedge sys_clk);
		read_chk(6'h04, 8'h30);
		bus_read(rca_pkg::OFS_SUBSEC);
		rd2 = rd;
		repeat (20) @(posedge sys_clk);
		bus_read(rca_pkg::OFS_SUBSEC);
		check({31'h0, rd !== rd2}, 32'h1);
		// Oscillator off must freeze the sub-second count
		bus_write(rca_pkg::OFS_CTRL2, 8'h00);
		bus_read(rca_pkg::OFS_SUBSEC);
		rd2 = rd;
		repeat (40) @(posedge sys_clk);
		read_chk(rca_pkg::OFS_SUBSEC, rd2[7:0]);
		bus_write(rca_pkg::OFS_CTRL2, 8'h08);
	endtask : t_halt

	task automatic t_round();
		bus_write(6'h08, 8'h10);
		bus_write(rca_pkg::OFS_CTRL2, 8'h0c);
		read_chk(6'h04, 8'h00);
		read_chk(6'h08, 8'h11);
		bus_write(6'h04, 8'h29);
		bus_write(rca_pkg::OFS_CTRL2, 8'h0c);
		read_chk(6'h04, 8'h00);
		read_chk(6'h08, 8'h11);
		bus_write(6'h08, 8'h59);
		bus_write(6'h04, 8'h40);
		bus_write(rca_pkg::OFS_CTRL2, 8'h0c);
		read_chk(6'h08, 8'h00);
		read_chk(6'h0c, 8'h02);
		bus_write(rca_pkg::OFS_CTRL2, 8'h0a);
		// At the short tick the settling wait is below one clock
		read_chk(rca_pkg::OFS_SUBSEC, 8'h00);
		read_chk(rca_pkg::OFS_CTRL2, 8'h08);
	endtask : t_round

	task automatic t_alarm();
		bus_write(6'h04, 8'h10);
		bus_write(6'h20, 8'h91);
		bus_write(6'h28, 8'h82);
		bus_write(rca_pkg::OFS_CTRL1, 8'h08);
		bus_write(rca_pkg::OFS_CTRL2, 8'h09);
		read_chk(rca_pkg::OFS_CTRL1, 8'h08);
		repeat (1100) @(posedge sys_clk);
		// Timebase stopped so the carry flag keeps what is written next
		bus_write(rca_pkg::OFS_CTRL2, 8'h01);
		read_chk(rca_pkg::OFS_CTRL1, 8'h89);
		check({31'h0, alarm_irq}, 32'h1);
		bus_write(rca_pkg::OFS_CTRL1, 8'h09);
		read_chk(rca_pkg::OFS_CTRL1, 8'h09);
		bus_write(rca_pkg::OFS_CTRL1, 8'h00);
		read_chk(rca_pkg::OFS_CTRL1, 8'h00);
		check({31'h0, alarm_irq}, 32'h0);
	endtask : t_alarm

	// Each wait covers the longest interval, so every nonzero code must flag and code 0 must not
	task automatic t_periodic();
		logic [2:0] p;
		for (int i = 0; i < 8; i++) begin
			p = 3'(i);
			bus_write(rca_pkg::OFS_CTRL2, {1'b0, p, 4'h9});
			repeat (2100) @(posedge sys_clk);
			read_chk(rca_pkg::OFS_CTRL2, {p != 3'h0, p, 4'h9});
			check({31'h0, periodic_irq}, {31'h0, p != 3'h0});
		end
	endtask : t_periodic

	task automatic t_carry();
		bus_write(rca_pkg::OFS_CTRL1, 8'h10);
		repeat (20) @(posedge sys_clk);
		read_chk(rca_pkg::OFS_CTRL1, 8'h90);
		check({31'h0, carry_irq}, 32'h1);
		// Carry seen: halt, read the seconds twice and check that both reads agree
		bus_write(rca_pkg::OFS_CTRL2, 8'h08);
		bus_read(6'h04);
		rd2 = rd;
		read_chk(6'h04, rd2[7:0]);
	endtask : t_carry

	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_halt();
		t_round();
		t_alarm();
		t_periodic();
		t_carry();
		finish_test();
	end

	// Run takes about 20k cycles; this allows roughly twice that
	initial begin
		#2000000;
		err_count++;
		finish_test();
	end
endmodule : test_rca_top
